// ===== hdl/ccs_consts.vh
// Constants for the complement and compare-skip execution block
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH
`define CCS_OPC_CPL 6'h07
`define CCS_OPC_CPEQ 7'h31
`define CCS_OPC_MSB 15
`define CCS_OPC_CPL_LSB 10
`define CCS_OPC_CPEQ_LSB 9
`define CCS_F_MSB 7
`define CCS_F_LSB 0
`define CCS_SIGN_BIT 7
`define CCS_BIT_D 9
`define CCS_BIT_A 8
`define CCS_IDX_LIMIT 8'h5F
`define CCS_ACC_SPLIT 8'h60
`define CCS_ACC_HIGH_BANK 4'hF
`define CCS_ZERO8 8'h00
`define CCS_ZERO12 12'h000
`define CCS_ZERO4 4'h0
`define CCS_PH_STEP 2'h1
`define CCS_Q1 2'h0
`define CCS_Q2 2'h1
`define CCS_Q3 2'h2
`define CCS_Q4 2'h3
`endif

// ===== hdl/ccs_exec.v
// Execution of complement-file and compare-equal-skip instructions
`timescale 1ns/1ns
`include "ccs_consts.vh"

// Notes on behaviour
// RULE1: Complement-file result is the bitwise inverse of the file byte.
// RULE2: Destination bit 0: result goes to working register, file untouched.
// RULE3: Destination bit 1: result written back to the file register.
// RULE4: Access bit 0: address resolved inside the access bank.
// RULE5: Access bit 1: bank select register chooses the register bank.
// RULE6: Extended set, access bit 0, address up to 95: indexed offset.
// RULE7: Compare-skip: unsigned equality, no flags, skip turns next to no-op.
module ccs_exec (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire instr_valid,
	input wire [15:0] instr,
	input wire ext_set_en,
	input wire [3:0] bank_select_register,
	input wire [11:0] idx_base,
	input wire [7:0] wreg_in,
	input wire [7:0] mem_rdata,
	output wire [11:0] mem_addr,
	output wire mem_rd,
	output wire mem_we,
	output wire [7:0] mem_wdata,
	output wire wreg_we,
	output wire [7:0] wreg_wdata,
	output wire flags_we,
	output wire flag_n,
	output wire flag_z,
	output wire skip_next,
	output wire [1:0] qphase
);

// Phase codes of the four-step instruction cycle
localparam [1:0] PH_Q1 = `CCS_Q1;
localparam [1:0] PH_Q2 = `CCS_Q2;
localparam [1:0] PH_Q3 = `CCS_Q3;
localparam [1:0] PH_Q4 = `CCS_Q4;

// State and output registers
reg [1:0] q_q;
reg [1:0] q_d;
reg is_cpl_q;
reg is_cpl_d;
reg is_cpeq_q;
reg is_cpeq_d;
reg dest_q;
reg dest_d;
reg [7:0] data_q;
reg [7:0] data_d;
reg [11:0] addr_q;
reg [11:0] addr_d;
reg [11:0] mem_addr_q;
reg [11:0] mem_addr_d;
reg mem_rd_q;
reg mem_rd_d;
reg mem_we_q;
reg mem_we_d;
reg [7:0] mem_wdata_q;
reg [7:0] mem_wdata_d;
reg wreg_we_q;
reg wreg_we_d;
reg [7:0] wreg_wdata_q;
reg [7:0] wreg_wdata_d;
reg flags_we_q;
reg flags_we_d;
reg flag_n_q;
reg flag_n_d;
reg flag_z_q;
reg flag_z_d;
reg skip_next_q;
reg skip_next_d;

// Decoded instruction fields
wire is_cpl;
wire is_cpeq;
wire is_known;
wire [7:0] f_field;
wire acc_sel;
wire dest_sel;
wire [11:0] eff_addr;
wire [7:0] comp_byte;
wire cpeq_equal;

function [11:0] resolve_addr;
	input [7:0] f;
	input a;
	input ext;
	input [3:0] bank;
	input [11:0] base;
	begin
		if (!a && ext && f <= `CCS_IDX_LIMIT)
			resolve_addr = base + {`CCS_ZERO4, f}; // [RULE6]
		else if (!a && f < `CCS_ACC_SPLIT)
			resolve_addr = {`CCS_ZERO4, f}; // [RULE4]
		else if (!a)
			resolve_addr = {`CCS_ACC_HIGH_BANK, f}; // [RULE4]
		else
			resolve_addr = {bank, f}; // [RULE5]
	end
endfunction

function [1:0] next_phase;
	input [1:0] q;
	begin
		next_phase = q + `CCS_PH_STEP;
	end
endfunction

assign f_field = instr[`CCS_F_MSB:`CCS_F_LSB];
assign acc_sel = instr[`CCS_BIT_A];
assign dest_sel = instr[`CCS_BIT_D];
assign is_cpl = instr[`CCS_OPC_MSB:`CCS_OPC_CPL_LSB] == `CCS_OPC_CPL;
assign is_cpeq = instr[`CCS_OPC_MSB:`CCS_OPC_CPEQ_LSB] == `CCS_OPC_CPEQ;
assign is_known = instr_valid & (is_cpl | is_cpeq);
assign eff_addr = resolve_addr(f_field, acc_sel, ext_set_en,
	bank_select_register, idx_base);
assign comp_byte = ~data_q; // [RULE1]
assign cpeq_equal = data_q == wreg_in; // [RULE7]

// Next-state logic; pulses drop unless a phase raises them
always @* begin
	q_d = next_phase(q_q);
	is_cpl_d = is_cpl_q;
	is_cpeq_d = is_cpeq_q;
	dest_d = dest_q;
	data_d = data_q;
	addr_d = addr_q;
	mem_addr_d = mem_addr_q;
	mem_rd_d = 1'h0;
	mem_we_d = 1'h0;
	mem_wdata_d = mem_wdata_q;
	wreg_we_d = 1'h0;
	wreg_wdata_d = wreg_wdata_q;
	flags_we_d = 1'h0;
	flag_n_d = flag_n_q;
	flag_z_d = flag_z_q;
	skip_next_d = 1'h0;
	case (q_q)
	PH_Q1: begin
		is_cpl_d = instr_valid & is_cpl;
		is_cpeq_d = instr_valid & is_cpeq;
		dest_d = dest_sel;
		addr_d = eff_addr; // [RULE4] [RULE5] [RULE6]
		mem_addr_d = eff_addr;
		mem_rd_d = is_known;
	end
	PH_Q2: begin
		data_d = mem_rdata;
	end
	PH_Q3: begin
		if (is_cpl_q)
			data_d = comp_byte; // [RULE1]
	end
	PH_Q4: begin
		if (is_cpl_q) begin
			flags_we_d = 1'h1;
			flag_n_d = data_q[`CCS_SIGN_BIT];
			flag_z_d = data_q == `CCS_ZERO8;
			if (dest_q) begin
				mem_addr_d = addr_q;
				mem_we_d = 1'h1; // [RULE3]
				mem_wdata_d = data_q;
			end else begin
				wreg_we_d = 1'h1; // [RULE2]
				wreg_wdata_d = data_q;
			end
		end
		if (is_cpeq_q)
			skip_next_d = cpeq_equal; // [RULE7]
		is_cpl_d = 1'h0;
		is_cpeq_d = 1'h0;
	end
	default: begin
		q_d = PH_Q1;
	end
	endcase
end

// Clock enable low freezes every register unless the asynchronous reset clears it
always @(posedge clk or posedge rst) begin
	if (rst) begin
		q_q <= PH_Q1;
		is_cpl_q <= 1'h0;
		is_cpeq_q <= 1'h0;
		dest_q <= 1'h0;
		data_q <= `CCS_ZERO8;
		addr_q <= `CCS_ZERO12;
		mem_addr_q <= `CCS_ZERO12;
		mem_rd_q <= 1'h0;
		mem_we_q <= 1'h0;
		mem_wdata_q <= `CCS_ZERO8;
		wreg_we_q <= 1'h0;
		wreg_wdata_q <= `CCS_ZERO8;
		flags_we_q <= 1'h0;
		flag_n_q <= 1'h0;
		flag_z_q <= 1'h0;
		skip_next_q <= 1'h0;
	end else if (ce) begin
		q_q <= q_d;
		is_cpl_q <= is_cpl_d;
		is_cpeq_q <= is_cpeq_d;
		dest_q <= dest_d;
		data_q <= data_d;
		addr_q <= addr_d;
		mem_addr_q <= mem_addr_d;
		mem_rd_q <= mem_rd_d;
		mem_we_q <= mem_we_d;
		mem_wdata_q <= mem_wdata_d;
		wreg_we_q <= wreg_we_d;
		wreg_wdata_q <= wreg_wdata_d;
		flags_we_q <= flags_we_d;
		flag_n_q <= flag_n_d;
		flag_z_q <= flag_z_d;
		skip_next_q <= skip_next_d;
	end
end

assign mem_addr = mem_addr_q;
assign mem_rd = mem_rd_q;
assign mem_we = mem_we_q;
assign mem_wdata = mem_wdata_q;
assign wreg_we = wreg_we_q;
assign wreg_wdata = wreg_wdata_q;
assign flags_we = flags_we_q;
assign flag_n = flag_n_q;
assign flag_z = flag_z_q;
assign skip_next = skip_next_q;
assign qphase = q_q;

endmodule

// ===== tb/ccs_exec_properties.sv
// Checker for the complement and compare-skip block
`timescale 1ns/1ns
module ccs_exec_chk (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire instr_valid,
	input wire ext_set_en,
	input wire mem_rd,
	input wire mem_we,
	input wire wreg_we,
	input wire flags_we,
	input wire flag_n,
	input wire flag_z,
	input wire skip_next,
	input wire [15:0] instr,
	input wire [3:0] bank_select_register,
	input wire [11:0] idx_base,
	input wire [11:0] mem_addr,
	input wire [7:0] mem_rdata,
	input wire [7:0] wreg_in,
	input wire [7:0] mem_wdata,
	input wire [7:0] wreg_wdata,
	input wire [1:0] qphase
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire tk = ce && qphase == 2'h0 && instr_valid;
	wire op = tk && (instr[15:10] == 6'h07 || instr[15:9] == 7'h31);
	wire acc = op && !instr[8];
	sequence op_s(logic [6:0] o);
		tk && instr[15:9] == o ##1 ce [*3] ##1 1'b1;
	endsequence
	sequence cpl_s;
		tk && instr[15:10] == 6'h07 ##1 ce [*3] ##1 1'b1;
	endsequence
	a_comp_wreg: assert property (op_s(7'h0E) |->
		wreg_we && !mem_we && wreg_wdata == ~$past(mem_rdata, 3))
		else $error("wreg");
	a_comp_file: assert property (op_s(7'h0F) |->
		mem_we && !wreg_we && mem_wdata == ~$past(mem_rdata, 3))
		else $error("file");
	a_comp_flags: assert property (cpl_s |-> flags_we &&
		flag_n == !$past(mem_rdata[7], 3) &&
		flag_z == ($past(mem_rdata, 3) == 8'hFF)) else $error("flags");
	a_bank_addr: assert property (op && instr[8] |=> mem_rd &&
		mem_addr == {$past(bank_select_register), $past(instr[7:0])})
		else $error("bank");
	a_access_lo: assert property (acc && !ext_set_en &&
		instr[7:0] < 8'h60 |=> mem_addr == {4'h0, $past(instr[7:0])})
		else $error("acc lo");
	a_access_hi: assert property (acc && instr[7:0] > 8'h5F |=>
		mem_addr == {4'hF, $past(instr[7:0])}) else $error("acc hi");
	a_indexed: assert property (acc && ext_set_en &&
		instr[7:0] < 8'h60 |=> mem_addr == $past(idx_base) +
		$past(instr[7:0])) else $error("indexed");
	a_skip_eq: assert property (op_s(7'h31) |-> !flags_we &&
		skip_next == ($past(mem_rdata, 3) == $past(wreg_in)))
		else $error("skip");
	a_freeze_hold: assert property (!ce |=> $stable(qphase) &&
		$stable(mem_addr) && $stable(mem_rd) && $stable(wreg_wdata))
		else $error("freeze");
endmodule
bind ccs_exec ccs_exec_chk u_chk (
	.clk(clk),
	.rst(rst),
	.ce(ce),
	.instr_valid(instr_valid),
	.ext_set_en(ext_set_en),
	.mem_rd(mem_rd),
	.mem_we(mem_we),
	.wreg_we(wreg_we),
	.flags_we(flags_we),
	.flag_n(flag_n),
	.flag_z(flag_z),
	.skip_next(skip_next),
	.instr(instr),
	.bank_select_register(bank_select_register),
	.idx_base(idx_base),
	.mem_addr(mem_addr),
	.mem_rdata(mem_rdata),
	.wreg_in(wreg_in),
	.mem_wdata(mem_wdata),
	.wreg_wdata(wreg_wdata),
	.qphase(qphase)
);

// ===== tb/ccs_exec_tb.sv
// Self-checking bench for the complement and compare-skip block
`timescale 1ns/1ns
module ccs_exec_tb;
	reg clk = 0, rst = 1, iv = 0, ext = 0, en = 1;
	reg [15:0] ins = 0;
	reg [3:0] bank = 4'h5;
	reg [11:0] base = 12'h100;
	reg [7:0] w = 0, rd = 0;
	wire [11:0] addr;
	wire [7:0] wd, wwd;
	wire mrd, mwe, wwe, skp, fwe, fn, fz;
	wire [1:0] qp;
	integer n_mismatch = 0, checks = 0, i;
	initial forever #5 clk = ~clk;
	ccs_exec DUT (.clk(clk), .rst(rst), .ce(en), .instr_valid(iv),
		.instr(ins), .ext_set_en(ext), .bank_select_register(bank),
		.idx_base(base), .wreg_in(w), .mem_rdata(rd), .mem_addr(addr),
		.mem_rd(mrd), .mem_we(mwe), .mem_wdata(wd), .wreg_we(wwe),
		.wreg_wdata(wwd), .flags_we(fwe), .flag_n(fn), .flag_z(fz),
		.skip_next(skp), .qphase(qp));
	task stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input [11:0] s, e);
		checks = checks + 1;
		if (s !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch %0s exp %h seen %h", nm, e, s);
		end
	endtask
	task exec(input [15:0] i_v, input [7:0] r_v, w_v);
		for (i = 0; i < 8 && qp !== 2'h0; i = i + 1) @(posedge clk) #1;
		chk("phase", qp, 2'h0);
		if (qp !== 2'h0) stop_test;
		ins = i_v; rd = r_v; w = w_v; iv = 1;
		@(posedge clk) #1 iv = 0;
	endtask
	task fin;
		repeat (3) @(posedge clk) #1;
	endtask
	task t_cpl_w;
		exec(16'h1C20, 8'h13, 8'h00);
		chk("addr", addr, 12'h020);
		chk("mrd", mrd, 1'h1);
		fin;
		chk("wreg", wwd, 8'hEC);
		chk("wwe", wwe, 1'h1);
		chk("mwe", mwe, 1'h0);
		chk("neg", fn, 1'h1);
		chk("zero", fz, 1'h0);
	endtask
	task t_cpl_f;
		exec(16'h1F34, 8'hA5, 8'h00);
		chk("addr", addr, 12'h534);
		fin;
		chk("file", wd, 8'h5A);
		chk("mwe", mwe, 1'h1);
		chk("wwe", wwe, 1'h0);
		chk("neg", fn, 1'h0);
	endtask
	task t_freeze;
		exec(16'h1C41, 8'hFF, 8'h00);
		en = 0;
		repeat (3) @(posedge clk) #1;
		chk("hold", qp, 2'h1);
		chk("held", mrd, 1'h1);
		en = 1;
		fin;
		chk("wreg", wwd, 8'h00);
		chk("zero", fz, 1'h1);
	endtask
	task t_cmp(input [15:0] i_v, input [7:0] w_v, input [11:0] a, input e);
		exec(i_v, 8'h77, w_v);
		chk("addr", addr, a);
		fin;
		chk("skip", skp, e);
		chk("flags", fwe, 1'h0);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		t_cpl_w;
		t_cpl_f;
		t_freeze;
		ext = 1;
		t_cmp(16'h625F, 8'h77, 12'h15F, 1'h1);
		t_cmp(16'h6260, 8'h78, 12'hF60, 1'h0);
		stop_test;
	end
endmodule
